//--- rtl/float_add_normalized_sequencer.sv
// Floating-point add-normalized sequencer with an AXI4-Lite register slave.
// Assumes a single clock and that software loads the float register store first.
`default_nettype none
module float_add_normalized_sequencer (
  input wire logic core_clk, // Core clock, 40 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [float_add_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [float_add_pkg::AXI_AW-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);
  import float_add_pkg::*;

  logic awReady_r, awHeld_r, wReady_r, wHeld_r, bValid_r, arReady_r, rValid_r;
  logic [1:0] bResp_r, rResp_r;
  logic [31:0] rData_r, wData_r;
  logic [3:0] wStrb_r;
  logic [7:0] awAddr_r;
  logic [15:0] instr_r;
  logic [31:0] addr_r, stgHi_r, stgLo_r;
  logic [1:0] mask_r;
  logic [3:0] lsIdx_r;
  logic longMode_r, busy_r, done_r;
  logic [1:0] cc_r;
  logic specErr_r, expOvf_r, expUnd_r, signif_r, zero_r, sign1_r, sign2_r;
  logic [3:0] branch_r, shiftCnt_r, eqCnt_r;
  logic [31:0] adHi_r, adLo_r, wrkHi_r, wrkLo_r;
  logic [63:0] fa_r, fb_r;
  logic [7:0] char_r;
  logic shiftSecond_r, resSign_r;
  seq_state_e state_r;
  logic [31:0] floatRegister [16];

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Register decode.
  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFF_CTRL) || (a == OFF_INSTR) || (a == OFF_ADDR) || (a == OFF_STG_HI) ||
          (a == OFF_STG_LO) || (a == OFF_MASK) || (a == OFF_STATUS) ||
          (a == OFF_LS_IDX) || (a == OFF_LS_DATA);
  endfunction

  wire [31:0] statusWord;
  assign statusWord = {12'h000, shiftCnt_r, branch_r, 1'b0, sign2_r, sign1_r, zero_r,
                       signif_r, expUnd_r, expOvf_r, specErr_r, cc_r, done_r, busy_r};

  function automatic logic [31:0] readReg(input logic [7:0] a);
    case (a)
      OFF_CTRL: readReg = {30'h0, longMode_r, 1'b0};
      OFF_INSTR: readReg = {16'h0000, instr_r};
      OFF_ADDR: readReg = addr_r;
      OFF_STG_HI: readReg = stgHi_r;
      OFF_STG_LO: readReg = stgLo_r;
      OFF_MASK: readReg = {30'h0, mask_r};
      OFF_STATUS: readReg = statusWord;
      OFF_LS_IDX: readReg = {28'h0, lsIdx_r};
      OFF_LS_DATA: readReg = floatRegister[lsIdx_r];
      default: readReg = 32'h0000_0000;
    endcase
  endfunction

  wire doWrite, wrHit, startReq, busWe;
  wire [31:0] byteMask, wrVal;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign wrHit = hit(awAddr_r);
  assign byteMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  assign wrVal = (readReg(awAddr_r) & ~byteMask) | (wData_r & byteMask);
  assign startReq = doWrite && (awAddr_r == OFF_CTRL) && wrVal[CTRL_START_BIT] && !busy_r;
  assign busWe = doWrite && (awAddr_r == OFF_LS_DATA) && !busy_r;

  // Write channel: address and data are taken independently, response after both.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= WORD_RST;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else begin
      awReady_r <= !awHeld_r && !bValid_r && !(s_axi_awvalid && awReady_r) && !doWrite;
      wReady_r <= !wHeld_r && !bValid_r && !(s_axi_wvalid && wReady_r) && !doWrite;
      if (s_axi_awvalid && awReady_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read channel: data one cycle after the address is taken.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= WORD_RST;
      rResp_r <= RESP_OKAY;
    end else begin
      arReady_r <= !rValid_r && !(s_axi_arvalid && arReady_r);
      if (s_axi_arvalid && arReady_r) begin
        rValid_r <= 1'b1;
        rData_r <= readReg(s_axi_araddr);
        rResp_r <= hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_r && s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  // Software registers; operand setup registers are frozen while busy.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instr_r <= INSTR_RST;
      addr_r <= WORD_RST;
      stgHi_r <= WORD_RST;
      stgLo_r <= WORD_RST;
      mask_r <= MASK_RST;
      lsIdx_r <= IDX_RST;
    end else if (doWrite && !busy_r) begin
      if (awAddr_r == OFF_INSTR) instr_r <= wrVal[15:0];
      if (awAddr_r == OFF_ADDR) addr_r <= wrVal;
      if (awAddr_r == OFF_STG_HI) stgHi_r <= wrVal;
      if (awAddr_r == OFF_STG_LO) stgLo_r <= wrVal;
      if (awAddr_r == OFF_MASK) mask_r <= wrVal[1:0];
      if (awAddr_r == OFF_LS_IDX) lsIdx_r <= wrVal[3:0];
    end
  end

  // Operand fields and characteristic difference.
  wire [3:0] reg1, reg2, reg1Lo, reg2Lo;
  assign reg1 = instr_r[7:4];
  assign reg2 = instr_r[3:0];
  assign reg1Lo = reg1 + 4'h1;
  assign reg2Lo = reg2 + 4'h1;
  wire specBad;
  assign specBad = reg1[0] || reg1[3] || (longMode_r && (reg2[0] || reg2[3]));
  wire [31:0] storageWord;
  assign storageWord = addr_r[ADDR_HALF_BIT] ? stgLo_r : stgHi_r;

  wire [6:0] char1, char2;
  wire [8:0] diffSum;
  wire [7:0] diff, diffMag;
  wire carryOut, diffZero, inRange, unlike;
  assign char1 = adHi_r[30:24];
  assign char2 = wrkHi_r[30:24];
  assign diffSum = {2'b00, char2} + {1'b0, ~{1'b0, char1}} + 9'h001;
  assign carryOut = diffSum[8];
  assign diff = diffSum[7:0];
  assign diffMag = carryOut ? diff : 8'(~diff + 8'h01);
  assign diffZero = (diff == 8'h00);
  assign unlike = adHi_r[31] ^ wrkHi_r[31];
  // A difference of -16 also reads 1111 on top but is beyond range.
  assign inRange = longMode_r ?
                   (carryOut ? (diff[7:4] == 4'h0) : (diff[7:4] == 4'hF && diff[3:0] != 4'h0))
                   : (diffMag <= SHORT_RANGE);
  wire [3:0] branchAddr;
  assign branchAddr = {carryOut, unlike, inRange, diffZero};

  wire [63:0] opA, opB;
  assign opA = {4'h0, adHi_r[23:0], adLo_r, 4'h0};
  assign opB = {4'h0, wrkHi_r[23:0], wrkLo_r, 4'h0};

  // Fraction adder: results are always produced in true form.
  wire aGeB;
  wire [63:0] sumAlike, sumAB, sumBA, sumTrue;
  assign aGeB = fa_r >= fb_r;
  assign sumAlike = fa_r + fb_r;
  assign sumAB = fa_r - fb_r;
  assign sumBA = fb_r - fa_r;
  assign sumTrue = !unlike ? sumAlike : (aGeB ? sumAB : sumBA);

  wire fracZero, fracNormal, expOver, expUnder;
  assign fracZero = (fa_r[59:0] == 60'h0);
  assign fracNormal = (fa_r[59:56] != 4'h0);
  assign expOver = char_r[7] && !char_r[6];
  assign expUnder = char_r[7] && char_r[6];

  wire [31:0] resultWord, trueZero;
  assign trueZero = 32'h0000_0000;
  assign resultWord = {resSign_r, char_r[6:0], fa_r[59:36]};

  // Store writes requested by the sequence.
  logic seqHiWe, seqLoWe;
  logic [31:0] seqHiData, seqLoData;
  always_comb begin
    seqHiWe = 1'b0;
    seqLoWe = 1'b0;
    seqHiData = resultWord;
    seqLoData = fa_r[35:4];
    if (state_r == S_STLOW && longMode_r) begin
      seqLoWe = 1'b1;
    end
    if (state_r == S_STHIGH) begin
      seqHiWe = 1'b1;
      if (fracZero) begin
        seqHiData = mask_r[MASK_SIGNIF_BIT] ? {1'b0, char_r[6:0], 24'h00_0000} : trueZero;
        seqLoWe = longMode_r;
        seqLoData = trueZero;
      end else if (expUnder && !mask_r[MASK_UNDER_BIT]) begin
        seqHiData = trueZero;
        seqLoWe = longMode_r;
        seqLoData = trueZero;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (busWe) floatRegister[lsIdx_r] <= wrVal;
    if (seqLoWe) floatRegister[reg1Lo] <= seqLoData;
    if (seqHiWe) floatRegister[reg1] <= seqHiData;
  end

  // Operation sequencer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      longMode_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cc_r <= CC_ZERO;
      specErr_r <= 1'b0;
      expOvf_r <= 1'b0;
      expUnd_r <= 1'b0;
      signif_r <= 1'b0;
      zero_r <= 1'b0;
      sign1_r <= 1'b0;
      sign2_r <= 1'b0;
      branch_r <= 4'h0;
      shiftCnt_r <= 4'h0;
      eqCnt_r <= 4'h0;
      adHi_r <= WORD_RST;
      adLo_r <= WORD_RST;
      wrkHi_r <= WORD_RST;
      wrkLo_r <= WORD_RST;
      fa_r <= 64'h0;
      fb_r <= 64'h0;
      char_r <= 8'h00;
      shiftSecond_r <= 1'b0;
      resSign_r <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (startReq) begin
            longMode_r <= wrVal[CTRL_LONG_BIT];
            busy_r <= 1'b1;
            done_r <= 1'b0;
            specErr_r <= 1'b0;
            expOvf_r <= 1'b0;
            expUnd_r <= 1'b0;
            signif_r <= 1'b0;
            zero_r <= 1'b0;
            shiftCnt_r <= SHIFT_START;
            adLo_r <= WORD_RST;
            wrkLo_r <= WORD_RST;
            state_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (specBad) begin
            specErr_r <= 1'b1;
            state_r <= S_FINISH;
          end else begin
            state_r <= S_LOADA;
          end
        end
        S_LOADA: begin
          if (longMode_r) begin
            adHi_r <= floatRegister[reg1];
            wrkHi_r <= floatRegister[reg2];
          end else begin
            wrkHi_r <= floatRegister[reg1];
          end
          state_r <= S_LOADB;
        end
        S_LOADB: begin
          if (longMode_r) begin
            adLo_r <= floatRegister[reg1Lo];
            state_r <= S_LOADC;
          end else begin
            adHi_r <= wrkHi_r;
            wrkHi_r <= storageWord;
            state_r <= S_BRANCH;
          end
        end
        S_LOADC: begin
          wrkLo_r <= floatRegister[reg2Lo];
          state_r <= S_BRANCH;
        end
        S_BRANCH: begin
          sign1_r <= adHi_r[31];
          sign2_r <= wrkHi_r[31];
          branch_r <= branchAddr;
          shiftSecond_r <= !carryOut;
          char_r <= {1'b0, carryOut ? char2 : char1};
          fa_r <= opA;
          fb_r <= opB;
          eqCnt_r <= EQ_DONE - diffMag[3:0];
          if (!inRange) begin
            // Out of range: the smaller operand contributes nothing.
            if (carryOut) fa_r <= 64'h0;
            else fb_r <= 64'h0;
            state_r <= S_ADD;
          end else if (diffZero) begin
            state_r <= S_ADD;
          end else begin
            state_r <= S_EQUAL;
          end
        end
        S_EQUAL: begin
          if (shiftSecond_r) fb_r <= fb_r >> shiftCnt_r;
          else fa_r <= fa_r >> shiftCnt_r;
          eqCnt_r <= eqCnt_r + 4'h1;
          if (eqCnt_r + 4'h1 == EQ_DONE) state_r <= S_ADD;
        end
        S_ADD: begin
          fa_r <= sumTrue;
          fb_r <= sumTrue;
          zero_r <= (sumTrue[59:0] == 60'h0);
          resSign_r <= (sumTrue[59:0] == 60'h0) ? 1'b0 :
                       (!unlike || aGeB) ? adHi_r[31] : wrkHi_r[31];
          state_r <= S_OVFL;
        end
        S_OVFL: begin
          if (fa_r[63:60] != 4'h0) begin
            fa_r <= fa_r >> shiftCnt_r;
            char_r <= char_r + 8'h01;
          end
          state_r <= S_STLOW;
        end
        S_STLOW: begin
          if (!fracZero && !fracNormal) state_r <= S_NORM;
          else state_r <= S_STHIGH;
        end
        S_NORM: begin
          fa_r <= fa_r << shiftCnt_r;
          char_r <= char_r - 8'h01;
          state_r <= S_STLOW;
        end
        S_STHIGH: begin
          if (fracZero) begin
            cc_r <= CC_ZERO;
            signif_r <= mask_r[MASK_SIGNIF_BIT];
          end else if (expOver) begin
            expOvf_r <= 1'b1;
          end else if (expUnder) begin
            expUnd_r <= mask_r[MASK_UNDER_BIT];
            if (!mask_r[MASK_UNDER_BIT]) cc_r <= CC_ZERO;
          end else begin
            cc_r <= resSign_r ? CC_NEG : CC_POS;
          end
          state_r <= S_FINISH;
        end
        S_FINISH: begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          busy_r <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- rtl/float_add_pkg.sv
// Shared constants for the floating-point add-normalized sequencer.
// Assumes a 32-bit AXI4-Lite register bus and one 40 MHz core clock.
`default_nettype none
package float_add_pkg;
  localparam int AXI_AW = 8;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_STG_HI = 8'h0C;
  localparam logic [7:0] OFF_STG_LO = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_LS_IDX = 8'h1C;
  localparam logic [7:0] OFF_LS_DATA = 8'h20;
  // Field positions.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_LONG_BIT = 1;
  localparam int MASK_UNDER_BIT = 0;
  localparam int MASK_SIGNIF_BIT = 1;
  localparam int ADDR_HALF_BIT = 10;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CC_LSB = 2;
  localparam int ST_SPEC = 4;
  localparam int ST_EXPOVF = 5;
  localparam int ST_EXPUND = 6;
  localparam int ST_SIGNIF = 7;
  localparam int ST_ZERO = 8;
  localparam int ST_SIGN1 = 9;
  localparam int ST_SIGN2 = 10;
  localparam int ST_BRANCH_LSB = 12;
  localparam int ST_SHIFT_LSB = 16;
  // Reset values.
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [3:0] IDX_RST = 4'h0;
  // Condition codes and counts.
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_NEG = 2'h1;
  localparam logic [1:0] CC_POS = 2'h2;
  localparam logic [3:0] SHIFT_START = 4'h4;
  localparam logic [3:0] EQ_DONE = 4'hF;
  localparam logic [7:0] LONG_RANGE = 8'h0F;
  localparam logic [7:0] SHORT_RANGE = 8'h07;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CHECK = 4'h1, S_LOADA = 4'h3, S_LOADB = 4'h2,
    S_LOADC = 4'h6, S_BRANCH = 4'h7, S_EQUAL = 4'h5, S_ADD = 4'h4,
    S_OVFL = 4'hC, S_STLOW = 4'hD, S_NORM = 4'hF, S_STHIGH = 4'hE,
    S_FINISH = 4'hA
  } seq_state_e;
endpackage
`default_nettype wire

//--- testbench/float_add_normalized_sequencer_props.sv
// Checker for the sequencer's register bus and the status word it reports.
// Assumes it is bound to the sequencer and sees only that module's ports.
`default_nettype none
module float_add_normalized_sequencer_props (
  input wire logic core_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [float_add_pkg::AXI_AW-1:0] s_axi_awaddr, // Bus.
  input wire logic s_axi_awvalid, // Bus.
  input wire logic s_axi_awready, // Bus.
  input wire logic [31:0] s_axi_wdata, // Bus.
  input wire logic [3:0] s_axi_wstrb, // Bus.
  input wire logic s_axi_wvalid, // Bus.
  input wire logic s_axi_wready, // Bus.
  input wire logic [1:0] s_axi_bresp, // Bus.
  input wire logic s_axi_bvalid, // Bus.
  input wire logic s_axi_bready, // Bus.
  input wire logic [float_add_pkg::AXI_AW-1:0] s_axi_araddr, // Bus.
  input wire logic s_axi_arvalid, // Bus.
  input wire logic s_axi_arready, // Bus.
  input wire logic [31:0] s_axi_rdata, // Bus.
  input wire logic [1:0] s_axi_rresp, // Bus.
  input wire logic s_axi_rvalid, // Bus.
  input wire logic s_axi_rready // Bus.
);
  timeunit 1ns;
  timeprecision 100ps;
  import float_add_pkg::*;
  logic [7:0] rdAddr_r;
  logic [7:0] wrAddr_r;
  wire stRd = s_axi_rvalid && (rdAddr_r == OFF_STATUS);
  wire badRd = (rdAddr_r > OFF_LS_DATA) || (rdAddr_r[1:0] != 2'h0);
  wire badWr = (wrAddr_r > OFF_LS_DATA) || (wrAddr_r[1:0] != 2'h0);
  wire [3:0] br = s_axi_rdata[ST_BRANCH_LSB+:4];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdAddr_r <= 8'h00;
      wrAddr_r <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rdAddr_r <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wrAddr_r <= s_axi_awaddr;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_ready_drop: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address taken twice");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_unmapped: assert property (s_axi_rvalid && badRd |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_write_unmapped: assert property (s_axi_bvalid && badWr |-> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write");
  a_cc_legal: assert property (stRd |-> s_axi_rdata[ST_CC_LSB+:2] != 2'h3)
    else $error("condition code out of range");
  a_zero_cc: assert property (stRd && s_axi_rdata[ST_ZERO] && s_axi_rdata[ST_DONE]
    |-> s_axi_rdata[ST_CC_LSB+:2] == CC_ZERO) else $error("zero result code");
  a_zero_carry: assert property (stRd && br[0] |-> br[3] && br[1])
    else $error("zero difference without carry");
  a_shift_four: assert property (stRd && s_axi_rdata[ST_DONE]
    |-> s_axi_rdata[ST_SHIFT_LSB+:4] == SHIFT_START) else $error("shift count");
  c_zero: cover property (stRd && s_axi_rdata[ST_ZERO]);
  c_bad_write: cover property (s_axi_bvalid && badWr);
  c_overflow: cover property (stRd && s_axi_rdata[ST_EXPOVF]);
endmodule
bind float_add_normalized_sequencer float_add_normalized_sequencer_props u_props (
  .core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- testbench/storage_doubleword_model.sv
// Main storage model that answers with whole doublewords.
// Assumes the bench copies both words of the pair into the storage registers.
`default_nettype none
module storage_doubleword_model (
  input wire logic [31:0] addr, // Byte address of the operand.
  output logic [31:0] hiWord, // First word of the doubleword.
  output logic [31:0] loWord // Second word of the doubleword.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] mem [2];
  initial begin
    mem[0] = 64'h41200000_41300000;
    mem[1] = 64'h80080000_7F800000;
  end
  // Storage is addressed by doubleword, so the word-select bit plays no part here.
  assign hiWord = mem[addr[11]][63:32];
  assign loWord = mem[addr[11]][31:0];
endmodule
`default_nettype wire

//--- testbench/test_float_add_normalized_sequencer.sv
// Self-checking bench for the float add-normalized sequencer.
// Assumes the package, the sequencer, its checker and the storage model are compiled first.
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_float_add_normalized_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import float_add_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, st, hiWord, loWord, stgAddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrs, wrs;
  int bad_count = 0, total_checks = 0;
  float_add_normalized_sequencer DUT (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  storage_doubleword_model stg (.addr(stgAddr), .hiWord(hiWord), .loWord(loWord));
  always #12.5 core_clk = ~core_clk;
  // Handshakes are judged at the rising edge on the values that stood before it.
  // Each valid is held until its own ready is seen; the status poll in run gives up after 300 reads, and the watchdog ends any other wait.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit awDone = 1'b0, wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (!awDone && s_axi_awready === 1'h1) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wDone && s_axi_wready === 1'h1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge core_clk);
    while (s_axi_bvalid !== 1'h1);
    wrs = s_axi_bresp;
    `CHK(wrs, (a > OFF_LS_DATA) ? RESP_SLVERR : RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge core_clk);
    while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk);
    while (s_axi_rvalid !== 1'h1);
    rdv = s_axi_rdata;
    rrs = s_axi_rresp;
    `CHK(rrs, (a > OFF_LS_DATA) ? RESP_SLVERR : RESP_OKAY)
  endtask
  task automatic ld(input logic [3:0] i, input logic [31:0] v);
    wr(OFF_LS_IDX, {28'h0, i});
    wr(OFF_LS_DATA, v);
  endtask
  task automatic cw(input logic [3:0] i, input logic [31:0] v);
    wr(OFF_LS_IDX, {28'h0, i});
    rd(OFF_LS_DATA);
    `CHK(rdv, v)
  endtask
  task automatic run(input logic lng, input logic [15:0] ins, input logic [31:0] ad,
      input logic [1:0] mk);
    int n = 0;
    stgAddr = ad;
    wr(OFF_ADDR, ad);
    wr(OFF_STG_HI, hiWord);
    wr(OFF_STG_LO, loWord);
    wr(OFF_MASK, {30'h0, mk});
    wr(OFF_INSTR, {16'h0, ins});
    wr(OFF_CTRL, {30'h0, lng, 1'h1});
    do begin
      rd(OFF_STATUS);
      n++;
    end while (rdv[ST_BUSY] !== 1'h0 && n < 300);
    `CHK(rdv[ST_BUSY], 1'h0)
    st = rdv;
  endtask
  task t_bus;
    rd(OFF_MASK);
    `CHK(rdv[1:0], MASK_RST)
    rd(8'h40);
    `CHK(rdv, 32'h0)
    wr(8'h44, 32'h12345678);
    $display("test bus done");
  endtask
  task t_short;
    ld(0, 32'h41100000);
    ld(1, 32'h0BADC0DE);
    run(1'h0, 16'h0000, 32'h400, 2'h0);
    cw(0, 32'h41400000);
    `CHK(st[ST_CC_LSB+:2], CC_POS)
    ld(0, 32'h41100000);
    run(1'h0, 16'h0000, 32'h000, 2'h0);
    cw(0, 32'h41300000);
    cw(1, 32'h0BADC0DE);
    $display("test short done");
  endtask
  task t_long;
    ld(2, 32'h42100000);
    ld(3, 32'h0);
    ld(4, 32'h41100000);
    ld(5, 32'h00000010);
    run(1'h1, 16'h0024, 32'h0, 2'h0);
    cw(2, 32'h42110000);
    cw(3, 32'h00000001);
    `CHK(st[ST_BRANCH_LSB+:4], 4'h2)
    `CHK(st[ST_SHIFT_LSB+:4], SHIFT_START)
    ld(4, 32'h41100000);
    ld(5, 32'h0);
    ld(6, 32'hC1100000);
    ld(7, 32'h00000001);
    run(1'h1, 16'h0046, 32'h0, 2'h0);
    cw(4, 32'hB4100000);
    cw(5, 32'h0);
    `CHK(st[ST_CC_LSB+:2], CC_NEG)
    `CHK(st[ST_SIGN2:ST_SIGN1], 2'h2)
    `CHK(st[ST_BRANCH_LSB+:4], 4'hF)
    ld(0, 32'h50100000);
    ld(1, 32'h00000005);
    ld(2, 32'h40100000);
    run(1'h1, 16'h0002, 32'h0, 2'h0);
    cw(0, 32'h50100000);
    `CHK(st[ST_BRANCH_LSB+1], 1'h0)
    $display("test long done");
  endtask
  task t_zero;
    for (int m = 0; m < 2; m++) begin
      ld(0, 32'h41100000);
      ld(1, 32'h0);
      ld(2, 32'hC1100000);
      ld(3, 32'h0);
      run(1'h1, 16'h0002, 32'h0, {m[0], 1'h0});
      cw(0, m ? 32'h41000000 : 32'h0);
      cw(1, 32'h0);
      `CHK(st[ST_CC_LSB+:2], CC_ZERO)
      `CHK(st[ST_SIGNIF], m[0])
    end
    $display("test zero done");
  endtask
  task t_exp;
    for (int m = 0; m < 2; m++) begin
      ld(0, 32'h00100000);
      run(1'h0, 16'h0000, 32'h800, {1'h0, m[0]});
      cw(0, m ? 32'h7F800000 : 32'h0);
      `CHK(st[ST_EXPUND], m[0])
    end
    ld(0, 32'h7F800000);
    run(1'h0, 16'h0000, 32'hC00, 2'h0);
    cw(0, 32'h00100000);
    `CHK(st[ST_EXPOVF], 1'h1)
    ld(1, 32'h12345678);
    run(1'h1, 16'h0010, 32'h0, 2'h0);
    `CHK(st[ST_SPEC], 1'h1)
    cw(1, 32'h12345678);
    $display("test exponent done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    t_bus;
    t_short;
    t_long;
    t_zero;
    t_exp;
    stop_test;
  end
endmodule
`default_nettype wire
